/* File: hw/dls_defines.svh */
// constants of the drive link request scheduler
`ifndef DLS_DEFINES_SVH
`define DLS_DEFINES_SVH

`define DLS_NCH           2
`define DLS_NSLOT         4
`define DLS_CLK_KHZ       50000
`define DLS_GAP_MS        15
`define DLS_GAP_CYCLES    (`DLS_GAP_MS * `DLS_CLK_KHZ)
`define DLS_MS_CYCLES     (`DLS_CLK_KHZ)

// serial error codes, decimal 6301 / 3801 / 6320 / 3820
`define DLS_CODE_SER_CH1  16'h189d
`define DLS_CODE_SER_CH2  16'h0ed9
`define DLS_CODE_DRV_CH1  16'h18b0
`define DLS_CODE_DRV_CH2  16'h0eec
`define DLS_CODE_TIMEOUT  16'h0001

// register map, byte offsets, channel block stride 0x10
`define DLS_CH_STRIDE     8'h10
`define DLS_REG_WAIT      4'h0
`define DLS_REG_STATUS    4'h2
`define DLS_REG_SER_CODE  4'h4
`define DLS_REG_DRV_CODE  4'h6
`define DLS_REG_ERR_STEP  4'h8
`define DLS_REG_BAD_PARAM 4'ha
`define DLS_REG_EXEC_STEP 4'hc
`define DLS_WAIT_RESET    16'h0000

// status register bit positions
`define DLS_ST_BUSY       0
`define DLS_ST_SER_ERR    1
`define DLS_ST_DRV_ERR    2
`define DLS_ST_DRV_LATCH  3
`define DLS_ST_BLK_ERR    4

`endif

/* File: hw/dls_pkg.sv */
// types of the drive link request scheduler
package dls_pkg;

  typedef enum logic [2:0] {
    DLS_KIND_MONITOR,
    DLS_KIND_CONTROL,
    DLS_KIND_PARAM_READ,
    DLS_KIND_PARAM_WRITE,
    DLS_KIND_BLOCK_WRITE
  } dls_kind_e;

  typedef enum logic [1:0] {
    DLS_ERR_NONE,
    DLS_ERR_SERIAL,
    DLS_ERR_DRIVE
  } dls_err_e;

  typedef enum logic [1:0] {
    DLS_ST_IDLE,
    DLS_ST_GAP,
    DLS_ST_RUN,
    DLS_ST_HALT
  } dls_state_e;

  // one request slot, in program order
  typedef struct packed {
    logic        enable;
    dls_kind_e   kind;
    logic [15:0] step;
    logic        state_on;
  } dls_req_s;

  // answer from the serial link engine
  typedef struct packed {
    logic        valid;
    dls_err_e    err;
    logic [15:0] drv_code;
    logic        blk_err;
    logic [15:0] bad_param;
  } dls_done_s;

  // command towards the serial link engine
  typedef struct packed {
    logic        start;
    logic        hold;
    logic        abort;
    dls_kind_e   kind;
    logic [1:0]  slot;
  } dls_txn_s;

  typedef struct packed {
    logic port_busy;
    logic serial_err;
    logic drive_err;
    logic drive_latch;
    logic block_write_err;
  } dls_flag_s;

endpackage : dls_pkg

/* File: hw/dls_rise_detect.sv */
// rising edge detector for a group of request enables
`timescale 1ns/1ns
module dls_rise_detect #(
  parameter int W = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] prev_q;

  // previous level of every enable
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_q;

endmodule : dls_rise_detect

/* File: hw/dls_cycle_timer.sv */
// down counter that pulses once after a loaded number of cycles
`timescale 1ns/1ns
module dls_cycle_timer #(
  parameter int W = 20
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  input  wire logic         run_i,
  output logic              expire_o
);

  logic [W-1:0] cnt_q;
  logic         live_q;

  // count down while running, pulse while the count is at one or below
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_q  <= '0;
      live_q <= 1'b0;
    end else if (load_i) begin
      cnt_q  <= count_i;
      live_q <= 1'b1;
    end else if (live_q && run_i) begin
      if (cnt_q <= W'(1)) begin
        live_q <= 1'b0;
      end
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign expire_o = live_q && run_i && (cnt_q <= W'(1));

endmodule : dls_cycle_timer

/* File: hw/dls_scheduler.sv */
// drive link request scheduler, two channels
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "dls_defines.svh"
module dls_scheduler
  import dls_pkg::*;
#(
  parameter int GAP_CYCLES = `DLS_GAP_CYCLES,
  parameter int MS_CYCLES  = `DLS_MS_CYCLES
) (
  input  wire logic                                  clk_sys_i,
  input  wire logic                                  reset_i,
  input  wire logic                                  scan_end_i,
  input  wire logic                                  run_mode_i,
  input  wire dls_req_s  [`DLS_NCH-1:0][`DLS_NSLOT-1:0] req_i,
  input  wire dls_done_s [`DLS_NCH-1:0]              done_i,
  output dls_txn_s       [`DLS_NCH-1:0]              txn_o,
  output dls_flag_s      [`DLS_NCH-1:0]              flag_o,
  output logic                                       exec_complete_flag_o,
  input  wire logic      [7:0]                       reg_addr_i,
  input  wire logic      [15:0]                      reg_wdata_i,
  input  wire logic                                  reg_wr_i,
  input  wire logic                                  reg_rd_i,
  output logic           [15:0]                      reg_rdata_o
);

  localparam int NS = `DLS_NSLOT;

  ////////////////////////////////////////////////////////////////////////////
  // mode change detection and scan-aligned completion flag

  logic run_prev_q;
  logic run_start;
  logic [`DLS_NCH-1:0] ch_done;
  logic cmp_pend_q;
  logic exec_complete_q;

  // stop-to-run edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      run_prev_q <= 1'b1; // no false stop-to-run edge right after reset
    end else begin
      run_prev_q <= run_mode_i;
    end
  end
  assign run_start = run_mode_i & ~run_prev_q;

  // completion shows for the whole scan after the one it happened in
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmp_pend_q      <= 1'b0;
      exec_complete_q <= 1'b0;
    end else begin
      if (scan_end_i) begin
        exec_complete_q <= cmp_pend_q | (|ch_done);
      end
      if (|ch_done) begin
        cmp_pend_q <= ~scan_end_i; // cleared when the scan ends in this cycle; exec_complete_q takes the completion directly
      end else if (scan_end_i) begin
        cmp_pend_q <= 1'b0;
      end
    end
  end
  assign exec_complete_flag_o = exec_complete_q;

  ////////////////////////////////////////////////////////////////////////////
  // per channel scheduling

  logic [`DLS_NCH-1:0][15:0] wait_q;
  logic [`DLS_NCH-1:0][15:0] ser_code_q;
  logic [`DLS_NCH-1:0][15:0] drv_code_q;
  logic [`DLS_NCH-1:0][15:0] err_step_q;
  logic [`DLS_NCH-1:0][15:0] bad_param_q;
  logic [`DLS_NCH-1:0][15:0] exec_step_q;
  dls_flag_s [`DLS_NCH-1:0]  flag_q;
  logic [3:0]                reg_off;
  logic                      reg_ch;

  assign reg_ch  = (reg_addr_i[7:4] == 4'h1);
  assign reg_off = reg_addr_i[3:0];

  for (genvar c = 0; c < `DLS_NCH; c++) begin : g_ch
    dls_state_e    state_q;
    logic [NS-1:0] en;
    logic [NS-1:0] rise;
    logic [NS-1:0] pend_q;
    logic [1:0]    cur_q;
    logic [1:0]    pick;
    logic          pick_ok;
    logic          gap_expire;
    logic          ms_tick;
    logic [15:0]   resp_ms_q;
    logic          timeout;
    logic          finish;
    dls_err_e      fin_err;
    logic          halted;
    logic          start;

    for (genvar s = 0; s < NS; s++) begin : g_en
      assign en[s] = req_i[c][s].enable;
    end

    dls_rise_detect #(
      .W (NS)
    ) u_rise (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .level_i   (en),
      .rise_o    (rise)
    );

    // next slot in program order after the one last served
    always_comb begin
      logic [1:0] idx;
      idx     = 2'd0;
      pick    = 2'd0;
      pick_ok = 1'b0;
      for (int k = NS; k >= 1; k--) begin
        idx = cur_q + 2'(k);
        if (pend_q[idx] && en[idx]) begin
          pick    = idx;
          pick_ok = 1'b1;
        end
      end
    end

    assign halted  = !req_i[c][cur_q].state_on;
    assign timeout = (state_q == DLS_ST_RUN) && (wait_q[c] != 16'h0000) && (resp_ms_q >= wait_q[c]);
    assign finish  = (state_q == DLS_ST_RUN) && (done_i[c].valid || timeout);
    assign fin_err = done_i[c].valid ? done_i[c].err : DLS_ERR_DRIVE;
    assign start   = pick_ok && ((state_q == DLS_ST_IDLE) || ((state_q == DLS_ST_GAP) && gap_expire));
    assign ch_done[c] = finish;

    dls_cycle_timer #(
      .W (24)
    ) u_gap (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .load_i    (finish),
      .count_i   (24'(GAP_CYCLES)),
      .run_i     (state_q == DLS_ST_GAP),
      .expire_o  (gap_expire)
    );

    dls_cycle_timer #(
      .W (24)
    ) u_ms (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .load_i    (start || ms_tick),
      .count_i   (24'(MS_CYCLES)),
      .run_i     (state_q == DLS_ST_RUN),
      .expire_o  (ms_tick)
    );

    // response wait in milliseconds, frozen while halted
    always_ff @(posedge clk_sys_i) begin
      if (reset_i || start) begin
        resp_ms_q <= 16'h0000;
      end else if (ms_tick && resp_ms_q != 16'hffff) begin
        resp_ms_q <= resp_ms_q + 16'h0001;
      end
    end

    // pending requests: edge sets, repeat on hold, discard during gap
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        pend_q <= '0;
      end else begin
        for (int s = 0; s < NS; s++) begin
          if (rise[s]) begin
            pend_q[s] <= 1'b1;
          end else if (finish && cur_q == 2'(s) && en[s]) begin
            pend_q[s] <= 1'b1;
          end else if (start && pick == 2'(s)) begin
            pend_q[s] <= 1'b0;
          end else if (!en[s] && state_q != DLS_ST_RUN && state_q != DLS_ST_HALT) begin
            pend_q[s] <= 1'b0;
          end
        end
      end
    end

    // one transaction at a time; halt and resume with the state step
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        state_q <= DLS_ST_IDLE;
        cur_q   <= 2'(NS - 1);
      end else begin
        case (state_q)
          DLS_ST_IDLE: begin
            if (start) begin
              state_q <= DLS_ST_RUN;
              cur_q   <= pick;
            end
          end
          DLS_ST_GAP: begin
            if (start) begin
              state_q <= DLS_ST_RUN;
              cur_q   <= pick;
            end else if (gap_expire) begin
              state_q <= DLS_ST_IDLE;
            end
          end
          DLS_ST_RUN: begin
            if (finish) begin
              state_q <= DLS_ST_GAP;
            end else if (halted) begin
              state_q <= DLS_ST_HALT;
            end
          end
          DLS_ST_HALT: begin
            if (!halted) begin
              state_q <= DLS_ST_RUN;
            end
          end
          default: begin
            state_q <= DLS_ST_IDLE;
          end
        endcase
      end
    end

    // link command towards the serial engine
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        txn_o[c] <= '0;
      end else begin
        txn_o[c].start <= start;
        txn_o[c].abort <= timeout && !done_i[c].valid;
        txn_o[c].hold  <= (state_q == DLS_ST_HALT) || ((state_q == DLS_ST_RUN) && halted && !finish);
        if (start) begin
          txn_o[c].kind <= req_i[c][pick].kind;
          txn_o[c].slot <= pick;
        end
      end
    end

    // flags and error words, one outcome per request
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        flag_q[c]      <= '0;
        ser_code_q[c]  <= 16'h0000;
        drv_code_q[c]  <= 16'h0000;
        err_step_q[c]  <= 16'h0000;
        bad_param_q[c] <= 16'h0000;
        exec_step_q[c] <= 16'h0000;
      end else begin
        flag_q[c].port_busy <= start || (state_q == DLS_ST_HALT) || ((state_q == DLS_ST_RUN) && !finish);
        if (start) begin
          exec_step_q[c] <= req_i[c][pick].step;
        end
        if (run_start) begin
          flag_q[c].drive_err       <= 1'b0;
          flag_q[c].drive_latch     <= 1'b0;
          flag_q[c].block_write_err <= 1'b0;
          flag_q[c].serial_err      <= 1'b0;
          ser_code_q[c]             <= 16'h0000;
          drv_code_q[c]             <= 16'h0000;
          err_step_q[c]             <= 16'h0000;
          bad_param_q[c]            <= 16'h0000;
        end
        // an outcome in the mode change cycle still lands
        if (finish) begin
          flag_q[c].block_write_err <= done_i[c].valid && done_i[c].blk_err;
          if (done_i[c].valid && done_i[c].blk_err) begin
            bad_param_q[c] <= done_i[c].bad_param;
          end
          case (fin_err)
            DLS_ERR_SERIAL: begin
              flag_q[c].serial_err <= 1'b1;
              flag_q[c].drive_err  <= 1'b0;
              ser_code_q[c]        <= (c == 0) ? `DLS_CODE_SER_CH1 : `DLS_CODE_SER_CH2;
            end
            DLS_ERR_DRIVE: begin
              flag_q[c].serial_err  <= 1'b1;
              flag_q[c].drive_err   <= 1'b1;
              flag_q[c].drive_latch <= 1'b1;
              ser_code_q[c]         <= (c == 0) ? `DLS_CODE_DRV_CH1 : `DLS_CODE_DRV_CH2;
              err_step_q[c]         <= exec_step_q[c];
              drv_code_q[c]         <= done_i[c].valid ? done_i[c].drv_code : `DLS_CODE_TIMEOUT;
            end
            default: begin
              flag_q[c].serial_err <= 1'b0;
              flag_q[c].drive_err  <= 1'b0;
            end
          endcase
        end
      end
    end

    // response wait word, software writable
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        wait_q[c] <= `DLS_WAIT_RESET;
      end else if (reg_wr_i && reg_off == `DLS_REG_WAIT && (reg_addr_i[7:4] == 4'(c))) begin
        wait_q[c] <= reg_wdata_i;
      end
    end
  end

  assign flag_o = flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
      if (reg_addr_i[7:5] == 3'h0) begin
        case (reg_off)
          `DLS_REG_WAIT:      reg_rdata_o <= wait_q[reg_ch];
          `DLS_REG_STATUS:    reg_rdata_o <= {11'h000, flag_q[reg_ch].block_write_err, flag_q[reg_ch].drive_latch,
                                             flag_q[reg_ch].drive_err, flag_q[reg_ch].serial_err,
                                             flag_q[reg_ch].port_busy};
          `DLS_REG_SER_CODE:  reg_rdata_o <= ser_code_q[reg_ch];
          `DLS_REG_DRV_CODE:  reg_rdata_o <= drv_code_q[reg_ch];
          `DLS_REG_ERR_STEP:  reg_rdata_o <= err_step_q[reg_ch];
          `DLS_REG_BAD_PARAM: reg_rdata_o <= bad_param_q[reg_ch];
          `DLS_REG_EXEC_STEP: reg_rdata_o <= exec_step_q[reg_ch];
          default:            reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule : dls_scheduler

/* File: bench/dls_link_model.sv */
// serial link engine stand-in for one channel
`timescale 1ns/1ns
module dls_link_model
  import dls_pkg::*;
(
  input  wire dls_txn_s    txn_i,
  input  wire logic        clk_sys_i,
  input  wire dls_err_e    err_i,
  input  wire logic [15:0] lat_i,
  output dls_done_s        done_o
);
  logic [15:0] cnt = 16'h0000;
  logic [15:0] junk = 16'h0000;

  initial done_o = '0;

  ////////////////////////////////////////////////////////////////
  // answer after lat_i cycles; idle fields scramble every cycle
  always @(posedge clk_sys_i) begin
    junk <= junk + 16'h3b1d;
    done_o <= '0;
    done_o.drv_code <= junk;
    done_o.bad_param <= ~junk;
    if (txn_i.start) cnt <= lat_i;
    else if (txn_i.abort) cnt <= 16'h0000;
    else if (cnt != 16'h0000 && !txn_i.hold) begin
      cnt <= cnt - 16'h0001;
      if (cnt == 16'h0001) begin
        done_o.valid <= 1'b1;
        done_o.err <= err_i;
        done_o.drv_code <= 16'h00a5;
        done_o.blk_err <= (err_i == DLS_ERR_DRIVE);
        done_o.bad_param <= 16'h005a;
      end
    end
  end
endmodule : dls_link_model

/* File: bench/dls_scheduler_sva.sv */
// port checks for the drive link request scheduler
`timescale 1ns/1ns
`include "dls_defines.svh"
module dls_scheduler_sva
  import dls_pkg::*;
#(
  parameter int GAP_CYCLES = 20
) (
  input wire logic                     clk_sys_i,
  input wire logic                     reset_i,
  input wire logic                     scan_end_i,
  input wire logic                     run_mode_i,
  input wire dls_done_s [`DLS_NCH-1:0] done_i,
  input wire dls_txn_s  [`DLS_NCH-1:0] txn_o,
  input wire dls_flag_s [`DLS_NCH-1:0] flag_o,
  input wire logic                     exec_complete_flag_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  logic acc;
  int   idle_q;

  // answer accepted on channel one
  assign acc = done_i[0].valid && flag_o[0].port_busy && !txn_o[0].hold;

  // free cycles since the port last carried a transaction
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) idle_q <= GAP_CYCLES;
    else if (flag_o[0].port_busy) idle_q <= 0;
    else if (idle_q < GAP_CYCLES) idle_q <= idle_q + 1;
  end

  ////////////////////////////////////////////////////////////////
  a_busy_at_start: assert property (txn_o[0].start |-> flag_o[0].port_busy)
    else $error("busy low at start");
  a_busy_drops: assert property (acc |=> !flag_o[0].port_busy)
    else $error("busy stays after answer");
  a_runs_through: assert property (
    flag_o[0].port_busy && !acc && !txn_o[0].abort |=> flag_o[0].port_busy || txn_o[0].abort)
    else $error("transaction ended without answer");
  a_one_at_time: assert property (flag_o[0].port_busy |=> !txn_o[0].start)
    else $error("start while busy");
  a_gap_kept: assert property (txn_o[0].start |-> idle_q >= GAP_CYCLES)
    else $error("start inside gap");
  a_serial_flags: assert property (
    acc && done_i[0].err == DLS_ERR_SERIAL |=> flag_o[0].serial_err && !flag_o[0].drive_err)
    else $error("serial error flags wrong");
  a_drive_flags: assert property (
    acc && done_i[0].err == DLS_ERR_DRIVE |=> flag_o[0].serial_err && flag_o[0].drive_err
      && flag_o[0].drive_latch)
    else $error("drive error flags wrong");
  a_halt_blocks: assert property (txn_o[0].hold |-> !txn_o[0].start)
    else $error("start while halted");
  a_done_marks: assert property (acc |-> ##[1:25] exec_complete_flag_o)
    else $error("no completion after answer");
  a_scan_hold: assert property (exec_complete_flag_o && !scan_end_i |=> exec_complete_flag_o)
    else $error("completion shorter than a scan");
  a_run_clears: assert property (
    $rose(run_mode_i) |-> ##[1:2] !flag_o[0].drive_err && !flag_o[0].drive_latch)
    else $error("stop to run left drive error");

  c_start: cover property (txn_o[0].start);
  c_halt: cover property (txn_o[0].hold && flag_o[0].port_busy);
  c_drive_err: cover property (acc && done_i[0].err == DLS_ERR_DRIVE);
endmodule : dls_scheduler_sva

bind dls_scheduler dls_scheduler_sva #(.GAP_CYCLES(GAP_CYCLES)) i_dls_scheduler_sva (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scan_end_i(scan_end_i), .run_mode_i(run_mode_i),
  .done_i(done_i), .txn_o(txn_o), .flag_o(flag_o), .exec_complete_flag_o(exec_complete_flag_o));

/* File: bench/dls_scheduler_bench.sv */
// self-checking bench for the drive link request scheduler
`timescale 1ns/1ns
module dls_scheduler_bench
  import dls_pkg::*;
;
  localparam int GAP = 20;
  logic             clk_sys_i = 1'b0;
  logic             reset_i = 1'b1;
  logic             scan_end_i = 1'b0;
  logic             run_mode_i = 1'b1;
  dls_req_s  [1:0][3:0] req;
  dls_done_s [1:0]  done;
  dls_txn_s  [1:0]  txn;
  dls_flag_s [1:0]  flag;
  dls_err_e  [1:0]  err_cfg;
  logic [1:0][15:0] lat;
  logic             exec_cf;
  logic [7:0]       reg_addr = 8'h00;
  logic [15:0]      reg_wdata = 16'h0000;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [15:0]      rdata;
  logic [15:0]      d;
  logic [15:0]      st_exp [1:3] = '{16'h0002, 16'h001e, 16'h0008};
  int               error_cnt = 0;
  int               num_checks = 0;
  int               cyc = 0;
  int               n;

  dls_scheduler #(.GAP_CYCLES(GAP), .MS_CYCLES(10)) i_dls_scheduler (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scan_end_i(scan_end_i), .run_mode_i(run_mode_i),
    .req_i(req), .done_i(done), .txn_o(txn), .flag_o(flag), .exec_complete_flag_o(exec_cf),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata));
  for (genvar c = 0; c < 2; c++) begin : g_link
    dls_link_model i_dls_link_model (
      .clk_sys_i(clk_sys_i), .txn_i(txn[c]), .err_i(err_cfg[c]), .lat_i(lat[c]), .done_o(done[c]));
  end

  ////////////////////////////////////////////////////////////////
  always #10 clk_sys_i = ~clk_sys_i;

  // scan marker every ten cycles, hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    scan_end_i <= (cyc % 10 == 9);
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(string w, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", w, e, g);
      error_cnt++;
    end
  endtask : check

  task automatic reg_wr_t(logic [7:0] a, logic [15:0] v);
    @(posedge clk_sys_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask : reg_wr_t

  task automatic reg_rd_t(logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd_t

  task automatic rd_chk(logic [7:0] a, logic [15:0] e, string w);
    reg_rd_t(a, d);
    check(w, e, d);
  endtask : rd_chk

  task automatic en(int c, int s, logic v);
    @(posedge clk_sys_i);
    req[c][s].enable <= v;
  endtask : en

  // cycles until a start, -1 if none
  task automatic wait_start(int c, int lim, output int k);
    k = -1;
    for (int i = 0; i < lim && k < 0; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (txn[c].start === 1'b1) k = i;
    end
  endtask : wait_start

  task automatic go(int c);
    wait_start(c, 400, n);
    check("start", 16'h0001, 16'(n >= 0));
  endtask : go

  task automatic wait_free(int c);
    for (int i = 0; i < 400 && flag[c].port_busy !== 1'b0; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    check("busy", 16'h0000, 16'(flag[c].port_busy));
  endtask : wait_free

  // completion length in cycles
  task automatic pulse();
    int hi;
    hi = 0;
    for (int i = 0; i < 40 && exec_cf !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    do begin
      @(posedge clk_sys_i);
      #1;
      hi++;
    end while (exec_cf === 1'b1 && hi < 40);
    check("complete", 16'd10, 16'(hi));
  endtask : pulse

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////
  initial begin
    for (int c = 0; c < 2; c++) begin
      err_cfg[c] = DLS_ERR_NONE;
      lat[c] = 16'h0005;
      for (int s = 0; s < 4; s++) req[c][s] = '{1'b0, DLS_KIND_MONITOR, 16'h0100 + 16'(c * 16 + s), 1'b1};
    end
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    // every kind, enable dropped mid-run
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys_i);
      req[0][0].kind <= dls_kind_e'(k);
      en(0, 0, 1'b1);
      go(0);
      check("kind", 16'(k), 16'(txn[0].kind));
      en(0, 0, 1'b0);
      pulse();
      wait_free(0);
    end
    $display("test kinds done");
    en(0, 1, 1'b1);
    go(0);
    wait_free(0);
    wait_start(0, 400, n);
    check("gap", 16'h0001, 16'(n >= GAP - 1 && n <= GAP + 3));
    wait_free(0);
    en(0, 1, 1'b0);
    $display("test reissue done");
    @(posedge clk_sys_i);
    req[0][2].enable <= 1'b1;
    req[0][3].enable <= 1'b1;
    go(0);
    check("first slot", 16'h0002, 16'(txn[0].slot));
    wait_free(0);
    wait_start(0, 400, n);
    check("second slot", 16'h0003, 16'(txn[0].slot));
    check("second waits", 16'h0001, 16'(n >= GAP - 1));
    en(0, 2, 1'b0);
    en(0, 3, 1'b0);
    wait_free(0);
    $display("test order done");
    @(posedge clk_sys_i);
    req[0][0].enable <= 1'b1;
    req[0][1].enable <= 1'b1;
    go(0);
    en(0, 0, 1'b0);
    en(0, 1, 1'b0);
    wait_free(0);
    wait_start(0, 3 * GAP, n);
    check("discarded", 16'hffff, 16'(n));
    $display("test discard done");
    for (int c = 0; c < 2; c++) begin
      for (int s = 1; s < 4; s++) begin
        @(posedge clk_sys_i);
        err_cfg[c] <= dls_err_e'(s % 3);
        en(c, s, 1'b1);
        go(c);
        en(c, s, 1'b0);
        wait_free(c);
        rd_chk(8'(c * 16 + 2), st_exp[s], "status");
        if (s == 1) rd_chk(8'(c * 16 + 4), c ? 16'h0ed9 : 16'h189d, "ser code");
        if (s == 2) begin
          rd_chk(8'(c * 16 + 4), c ? 16'h0eec : 16'h18b0, "drv class");
          rd_chk(8'(c * 16 + 6), 16'h00a5, "drv code");
          rd_chk(8'(c * 16 + 8), 16'h0100 + 16'(c * 16 + s), "err step");
          rd_chk(8'(c * 16 + 12), 16'h0100 + 16'(c * 16 + s), "exec step");
          rd_chk(8'(c * 16 + 10), 16'h005a, "bad param");
        end
      end
    end
    $display("test errors done");
    @(posedge clk_sys_i);
    lat[0] <= 16'd30;
    en(0, 0, 1'b1);
    go(0);
    @(posedge clk_sys_i);
    req[0][0].state_on <= 1'b0;
    req[0][1].enable <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    check("hold", 16'h0001, 16'(txn[0].hold));
    wait_start(0, 60, n);
    check("halt start", 16'hffff, 16'(n));
    check("halt busy", 16'h0001, 16'(flag[0].port_busy));
    @(posedge clk_sys_i);
    req[0][0].state_on <= 1'b1;
    req[0][0].enable <= 1'b0;
    req[0][1].enable <= 1'b0;
    wait_free(0);
    check("hold off", 16'h0000, 16'(txn[0].hold));
    $display("test halt done");
    reg_wr_t(8'h00, 16'h0001);
    rd_chk(8'h00, 16'h0001, "wait word");
    rd_chk(8'hf0, 16'h0000, "unmapped");
    @(posedge clk_sys_i);
    lat[0] <= 16'd300;
    en(0, 2, 1'b1);
    go(0);
    en(0, 2, 1'b0);
    wait_free(0);
    rd_chk(8'h06, 16'h0001, "timeout code");
    reg_wr_t(8'h06, 16'hffff);
    rd_chk(8'h06, 16'h0001, "read only");
    reg_wr_t(8'h00, 16'h0000);
    $display("test wait word done");
    wait_free(0);
    @(posedge clk_sys_i);
    run_mode_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    run_mode_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    for (int c = 0; c < 2; c++) begin
      reg_rd_t(8'(c * 16 + 2), d);
      check("cleared", 16'h0000, d & 16'h001c);
      rd_chk(8'(c * 16 + 6), 16'h0000, "drv code");
      rd_chk(8'(c * 16 + 8), 16'h0000, "err step");
      rd_chk(8'(c * 16 + 10), 16'h0000, "bad param");
    end
    $display("test stop run done");
    conclude();
  end
endmodule : dls_scheduler_bench
